/* rtl/deep_sleep_cfg.svh */
// constants for the deep sleep state sequencer
`ifndef DEEP_SLEEP_CFG_SVH
`define DEEP_SLEEP_CFG_SVH
`define DS_WAKE_SRC_W 4
`define DS_TIMER_W 32
`define DS_MODE_STANDALONE 2'h0
`define DS_MODE_PSM 2'h1
`define DS_MODE_PSM_FALLBACK 2'h2
`define DS_BOOT_TIME_US 2000
`define DS_CLK_MHZ 25
`define DS_BOOT_CYCLES (`DS_BOOT_TIME_US * `DS_CLK_MHZ)
`define DS_WAKE_MARGIN 32'h00000010
`define DS_RST_WAKE_EN 4'h0
`endif

/* rtl/deep_sleep_pkg.sv */
// types for the deep sleep state sequencer
package deep_sleep_pkg;
  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'h0,
    MODE_PSM = 2'h1,
    MODE_PSM_FALLBACK = 2'h2,
    MODE_RSVD = 2'h3
  } sleep_mode_t;
  typedef struct packed {
    logic app_cpu_on;
    logic modem_cpu_on;
    logic detach_req;
    logic attach_req;
    logic tau_req;
  } power_ctl_t;
endpackage

/* rtl/ds_down_counter.sv */
// loadable down counter that pulses when it reaches zero
`timescale 1ns/100ps
module ds_down_counter #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic run_i,
  // status
  output logic done_o,
  output logic busy_o
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic done_reg;
  logic done_next;
  always_comb begin
    count_next = count_reg;
    done_next = 1'b0;
    if (load_i) begin
      count_next = value_i;
    end else if (run_i && count_reg != '0) begin
      count_next = count_reg - WIDTH'(1);
      done_next = (count_reg == WIDTH'(1));
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end
  assign done_o = done_reg;
  assign busy_o = (count_reg != '0);
endmodule

/* rtl/ds_wake_filter.sv */
// gates wake events with the enabled source set
`timescale 1ns/100ps
module ds_wake_filter #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // sources
  input wire logic [N-1:0] event_i,
  input wire logic [N-1:0] enable_i,
  input wire logic arm_i,
  // result
  output logic wake_o,
  output logic [N-1:0] cause_o
);
  logic [N-1:0] cause_reg;
  logic [N-1:0] cause_next;
  logic wake_reg;
  logic wake_next;
  always_comb begin
    cause_next = cause_reg;
    wake_next = 1'b0;
    // disabled sources never wake the device
    if (arm_i && |(event_i & enable_i)) begin
      cause_next = event_i & enable_i;
      wake_next = 1'b1;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause_reg <= '0;
      wake_reg <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      wake_reg <= wake_next;
    end
  end
  assign wake_o = wake_reg;
  assign cause_o = cause_reg;
endmodule

/* rtl/deep_sleep_state_sequencer.sv */
// sequencer for entry to and exit from the deepest sleep state
// What this block does
// - sleep only via standalone or PSM; processor off
// - leaving sleep always reboots: standalone into Active, PSM into TAU
// - three sleep mode selections accepted
// - stay asleep until an enabled wake
// - standalone works regardless of network support
// - standalone entry detaches first, then sleeps
// - standalone wake: boot, reattach, stay Active
// - PSM sleeps keeping registration context
// - PSM wake: boot then send TAU
// - after TAU, inactivity timeout re-enters sleep
// - wake config kept; changed only while active
// - power-on goes Active or sleep by request
// - wake timer, shortened below TAU in PSM
`include "deep_sleep_cfg.svh"
`timescale 1ns/100ps
module deep_sleep_state_sequencer #(
  parameter int WAKE_W = `DS_WAKE_SRC_W,
  parameter int TIMER_W = `DS_TIMER_W,
  parameter int BOOT_CYCLES = `DS_BOOT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // power-on strap, active low turn-on request
  input wire logic power_on_n_i,
  // host configuration
  input wire deep_sleep_pkg::sleep_mode_t mode_i,
  input wire logic [WAKE_W-1:0] wake_en_i,
  input wire logic wake_en_we_i,
  input wire logic [TIMER_W-1:0] wake_timer_i,
  input wire logic sleep_req_i,
  // network side
  input wire logic attached_i,
  input wire logic detach_done_i,
  input wire logic attach_done_i,
  input wire logic psm_granted_i,
  input wire logic psm_rejected_i,
  input wire logic [TIMER_W-1:0] tau_timer_i,
  input wire logic [TIMER_W-1:0] inactivity_i,
  input wire logic tau_sent_i,
  input wire logic traffic_i,
  // wake sources, one pulse per trigger
  input wire logic [WAKE_W-1:0] wake_event_i,
  // power control and status
  output deep_sleep_pkg::power_ctl_t ctl_o,
  output logic asleep_o,
  output logic active_o,
  output logic psm_cycle_o,
  output logic [WAKE_W-1:0] wake_en_o,
  output logic [WAKE_W-1:0] wake_cause_o,
  output logic mode_err_o
);
  typedef enum logic [8:0] {
    ST_POWERUP = 9'h001,
    ST_ACTIVE = 9'h002,
    ST_NEGOTIATE = 9'h004,
    ST_DETACH = 9'h008,
    ST_SLEEP = 9'h010,
    ST_BOOT = 9'h020,
    ST_ATTACH = 9'h040,
    ST_TAU = 9'h080,
    ST_PSM_IDLE = 9'h100
  } seq_state_t;

  seq_state_t state_reg;
  seq_state_t state_next;
  logic psm_reg;
  logic psm_next;
  logic [WAKE_W-1:0] wake_en_reg;
  logic [WAKE_W-1:0] wake_en_next;
  logic [TIMER_W-1:0] inact_reg;
  logic [TIMER_W-1:0] inact_next;
  logic err_reg;
  logic err_next;
  logic [TIMER_W-1:0] boot_count_reg;
  logic [TIMER_W-1:0] boot_count_next;
  deep_sleep_pkg::power_ctl_t ctl_reg;
  deep_sleep_pkg::power_ctl_t ctl_next;

  // timer wake and filtered wake
  logic timer_load;
  logic [TIMER_W-1:0] timer_value;
  logic timer_done;
  logic ext_wake;
  logic [WAKE_W-1:0] ext_cause;
  logic inact_load;
  logic inact_done;

  function automatic logic mode_is_psm(input deep_sleep_pkg::sleep_mode_t m);
    mode_is_psm = (m == deep_sleep_pkg::MODE_PSM) || (m == deep_sleep_pkg::MODE_PSM_FALLBACK);
  endfunction

  // in PSM the wake timer leads the TAU timer by DS_WAKE_MARGIN cycles, whatever BOOT_CYCLES is
  always_comb begin
    timer_value = wake_timer_i;
    if (psm_next) begin
      if (tau_timer_i > TIMER_W'(`DS_WAKE_MARGIN)) begin
        timer_value = tau_timer_i - TIMER_W'(`DS_WAKE_MARGIN);
      end else begin
        // a tiny TAU value still loads a count of one, a two-cycle sleep, rather than a count that never fires
        timer_value = TIMER_W'(1);
      end
    end
  end

  assign timer_load = (state_reg != ST_SLEEP) && (state_next == ST_SLEEP);
  assign inact_load = (state_reg == ST_TAU && tau_sent_i) || (state_reg == ST_PSM_IDLE && traffic_i);

  // a zero load never fires, so a standalone sleep without timer waits on pins only
  ds_down_counter #(
    .WIDTH(TIMER_W)
  ) u_wake_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .load_i(timer_load),
    .value_i(timer_value),
    .run_i(state_reg == ST_SLEEP),
    .done_o(timer_done),
    .busy_o()
  );

  // traffic keeps reloading the count, so only a full quiet spell ends the period
  ds_down_counter #(
    .WIDTH(TIMER_W)
  ) u_inactivity (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .load_i(inact_load),
    .value_i(inact_reg),
    .run_i(state_reg == ST_PSM_IDLE && !traffic_i),
    .done_o(inact_done),
    .busy_o()
  );

  ds_wake_filter #(
    .N(WAKE_W)
  ) u_wake_filter (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .event_i(wake_event_i),
    .enable_i(wake_en_reg),
    .arm_i(state_reg == ST_SLEEP),
    .wake_o(ext_wake),
    .cause_o(ext_cause)
  );

  always_comb begin
    state_next = state_reg;
    psm_next = psm_reg;
    wake_en_next = wake_en_reg;
    inact_next = inact_reg;
    err_next = err_reg;
    boot_count_next = boot_count_reg;
    ctl_next = ctl_reg;
    ctl_next.tau_req = 1'b0;
    ctl_next.detach_req = 1'b0;
    ctl_next.attach_req = 1'b0;
    // wake set is kept across cycles and only written while awake
    if (wake_en_we_i && (state_reg == ST_ACTIVE || state_reg == ST_PSM_IDLE)) begin
      wake_en_next = wake_en_i;
    end
    unique case (state_reg)
      ST_POWERUP: begin
        // strap sampled after reset release
        if (!power_on_n_i) begin
          state_next = ST_BOOT;
        end else begin
          psm_next = 1'b0;
          state_next = ST_SLEEP;
        end
      end
      ST_ACTIVE: begin
        if (sleep_req_i) begin
          err_next = (mode_i == deep_sleep_pkg::MODE_RSVD);
          if (mode_is_psm(mode_i)) begin
            state_next = ST_NEGOTIATE;
          end else if (mode_i == deep_sleep_pkg::MODE_STANDALONE) begin
            // standalone needs no PSM grant from the network, only a detach answer when attached
            psm_next = 1'b0;
            state_next = attached_i ? ST_DETACH : ST_SLEEP;
            ctl_next.detach_req = attached_i;
          end
        end
      end
      ST_NEGOTIATE: begin
        if (psm_granted_i) begin
          psm_next = 1'b1;
          inact_next = inactivity_i;
          state_next = ST_SLEEP;
        end else if (psm_rejected_i) begin
          if (mode_i == deep_sleep_pkg::MODE_PSM_FALLBACK) begin
            psm_next = 1'b0;
            state_next = attached_i ? ST_DETACH : ST_SLEEP;
            ctl_next.detach_req = attached_i;
          end else begin
            // without fallback the host is left in Active to choose again
            state_next = ST_ACTIVE;
          end
        end
      end
      ST_DETACH: begin
        if (detach_done_i) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // only an enabled source or the wake timer ends sleep
        if (ext_wake || timer_done) begin
          boot_count_next = TIMER_W'(BOOT_CYCLES);
          state_next = ST_BOOT;
        end
      end
      ST_BOOT: begin
        // both processors are up before the network hears from the device
        if (boot_count_reg <= TIMER_W'(1)) begin
          boot_count_next = '0;
          state_next = psm_reg ? ST_TAU : ST_ATTACH;
          ctl_next.tau_req = psm_reg;
          ctl_next.attach_req = !psm_reg;
        end else begin
          boot_count_next = boot_count_reg - TIMER_W'(1);
        end
      end
      ST_ATTACH: begin
        if (attach_done_i) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_TAU: begin
        if (tau_sent_i) begin
          state_next = ST_PSM_IDLE;
        end
      end
      ST_PSM_IDLE: begin
        if (inact_done) begin
          state_next = ST_SLEEP;
        end
      end
      default: begin
        state_next = ST_POWERUP;
      end
    endcase
    // parking the outside pin drivers while asleep is the host's job, not policed here
    // processor power follows the state; off only in sleep
    ctl_next.app_cpu_on = (state_next != ST_SLEEP);
    ctl_next.modem_cpu_on = (state_next != ST_SLEEP);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_POWERUP;
      psm_reg <= 1'b0;
      wake_en_reg <= WAKE_W'(`DS_RST_WAKE_EN);
      inact_reg <= '0;
      err_reg <= 1'b0;
      boot_count_reg <= '0;
      ctl_reg <= '0;
    end else begin
      state_reg <= state_next;
      psm_reg <= psm_next;
      wake_en_reg <= wake_en_next;
      inact_reg <= inact_next;
      err_reg <= err_next;
      boot_count_reg <= boot_count_next;
      ctl_reg <= ctl_next;
    end
  end

  // cause of the last wake, zero for a timer wake; held until the next wake
  logic [WAKE_W-1:0] cause_hold_reg;
  logic [WAKE_W-1:0] cause_hold_next;
  always_comb begin
    cause_hold_next = cause_hold_reg;
    if (ext_wake) begin
      cause_hold_next = ext_cause;
    end else if (timer_done) begin
      cause_hold_next = '0;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause_hold_reg <= '0;
    end else begin
      cause_hold_reg <= cause_hold_next;
    end
  end

  // status is decoded from the state register, so it shows one cycle after a request
  assign ctl_o = ctl_reg;
  assign asleep_o = (state_reg == ST_SLEEP);
  assign active_o = (state_reg == ST_ACTIVE) || (state_reg == ST_PSM_IDLE);
  assign psm_cycle_o = psm_reg;
  assign wake_en_o = wake_en_reg;
  assign wake_cause_o = cause_hold_reg;
  assign mode_err_o = err_reg;
endmodule

/* bench/deep_sleep_properties.sv */
// assertion checker for the deep sleep state sequencer
`timescale 1ns/100ps
module deep_sleep_properties #(
  parameter int WAKE_W = 4,
  parameter int TIMER_W = 32,
  parameter int BOOT_CYCLES = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // watched inputs
  input wire deep_sleep_pkg::sleep_mode_t mode_i,
  input wire logic [TIMER_W-1:0] wake_timer_i,
  input wire logic sleep_req_i,
  input wire logic attached_i,
  input wire logic [WAKE_W-1:0] wake_event_i,
  // watched outputs
  input wire deep_sleep_pkg::power_ctl_t ctl_o,
  input wire logic asleep_o,
  input wire logic active_o,
  input wire logic psm_cycle_o,
  input wire logic [WAKE_W-1:0] wake_en_o,
  input wire logic mode_err_o
);
  localparam int BOOT_MAX = BOOT_CYCLES + 8;
  logic [WAKE_W-1:0] hit;
  assign hit = wake_event_i & wake_en_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_sleep_cpu_off: assert property (asleep_o |-> !ctl_o.app_cpu_on && !ctl_o.modem_cpu_on)
    else $error("processor left on in sleep");
  a_enabled_wakes: assert property (asleep_o && hit != '0 |-> ##[1:3] !asleep_o)
    else $error("enabled wake not taken");
  // a timer wake may coincide, so only timerless standalone sleep is judged
  a_disabled_ignored: assert property (asleep_o && !psm_cycle_o && wake_timer_i == '0 &&
    hit == '0 && $past(hit) == '0 |=> asleep_o) else $error("woke on disabled source");
  // requests count only in Active proper, not in the power-saving active period
  a_detach_first: assert property (active_o && !psm_cycle_o && sleep_req_i && attached_i &&
    mode_i == deep_sleep_pkg::MODE_STANDALONE |-> ##[1:2] ctl_o.detach_req)
    else $error("no detach before sleep");
  a_detach_awake: assert property (ctl_o.detach_req |-> !asleep_o ##1 !asleep_o)
    else $error("slept before detach done");
  a_reattach_boot: assert property ($fell(asleep_o) && !psm_cycle_o |->
    ##[1:BOOT_MAX] ctl_o.attach_req) else $error("no reattach after wake");
  a_tau_after_boot: assert property ($fell(asleep_o) && psm_cycle_o |->
    ##[1:BOOT_MAX] ctl_o.tau_req) else $error("no update after wake");
  a_tau_cpu_on: assert property (ctl_o.tau_req |-> ctl_o.app_cpu_on && ctl_o.modem_cpu_on)
    else $error("update sent before boot");
  a_cfg_kept: assert property (asleep_o && $past(asleep_o) |-> $stable(wake_en_o))
    else $error("wake set changed in sleep");
  a_mode_reject: assert property (active_o && !psm_cycle_o && sleep_req_i &&
    mode_i == deep_sleep_pkg::MODE_RSVD |-> ##[0:2] mode_err_o ##0 !asleep_o)
    else $error("reserved mode not refused");
  c_sleep: cover property ($rose(asleep_o));
  c_tau: cover property (ctl_o.tau_req);
  c_mode_err: cover property (mode_err_o);
endmodule
bind deep_sleep_state_sequencer deep_sleep_properties #(.WAKE_W(WAKE_W), .TIMER_W(TIMER_W),
  .BOOT_CYCLES(BOOT_CYCLES)) props_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .mode_i(mode_i),
  .wake_timer_i(wake_timer_i), .sleep_req_i(sleep_req_i), .attached_i(attached_i),
  .wake_event_i(wake_event_i), .ctl_o(ctl_o), .asleep_o(asleep_o), .active_o(active_o),
  .psm_cycle_o(psm_cycle_o), .wake_en_o(wake_en_o), .mode_err_o(mode_err_o));

/* bench/net_model.sv */
// network side model answering the sequencer's requests after three cycles
`timescale 1ns/100ps
module net_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // requests
  input wire deep_sleep_pkg::power_ctl_t ctl_i,
  input wire logic neg_i,
  input wire logic support_i,
  // answers
  output logic attached_o,
  output logic detach_done_o,
  output logic attach_done_o,
  output logic granted_o,
  output logic rejected_o,
  output logic tau_sent_o
);
  logic [2:0][3:0] dly;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly <= '0;
      attached_o <= 1'b1;
    end else begin
      dly <= {dly[1:0], {neg_i, ctl_i.tau_req, ctl_i.attach_req, ctl_i.detach_req}};
      if (dly[2][0]) begin
        attached_o <= 1'b0;
      end else if (dly[2][1]) begin
        attached_o <= 1'b1;
      end
    end
  end
  assign detach_done_o = dly[2][0];
  assign attach_done_o = dly[2][1];
  assign tau_sent_o = dly[2][2];
  assign granted_o = dly[2][3] & support_i;
  assign rejected_o = dly[2][3] & ~support_i;
endmodule

/* bench/tb.sv */
// self-checking bench for the deep sleep state sequencer
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic pwr_n = 1'b0;
  deep_sleep_pkg::sleep_mode_t mode = deep_sleep_pkg::MODE_STANDALONE;
  logic [3:0] wen = 4'h0;
  logic wen_we = 1'b0;
  logic [31:0] wtimer = 32'h0;
  logic req = 1'b0;
  logic support = 1'b1;
  logic traffic = 1'b0;
  logic [3:0] evt = 4'h0;
  logic attached, det_done, att_done, granted, rejected, tau_sent;
  deep_sleep_pkg::power_ctl_t ctl;
  logic asleep, active, psm, merr;
  logic [3:0] wen_o, cause;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  deep_sleep_state_sequencer #(.BOOT_CYCLES(4)) deep_sleep_state_sequencer_i (
    .clock_i(clock), .arst_n_i(arst_n), .power_on_n_i(pwr_n), .mode_i(mode), .wake_en_i(wen),
    .wake_en_we_i(wen_we), .wake_timer_i(wtimer), .sleep_req_i(req), .attached_i(attached),
    .detach_done_i(det_done), .attach_done_i(att_done), .psm_granted_i(granted),
    .psm_rejected_i(rejected), .tau_timer_i(32'h00000040), .inactivity_i(32'h0000000A),
    .tau_sent_i(tau_sent), .traffic_i(traffic), .wake_event_i(evt), .ctl_o(ctl),
    .asleep_o(asleep), .active_o(active), .psm_cycle_o(psm), .wake_en_o(wen_o),
    .wake_cause_o(cause), .mode_err_o(merr));
  net_model net_model_i (.clock_i(clock), .arst_n_i(arst_n), .ctl_i(ctl),
    .neg_i(active && req && mode inside {deep_sleep_pkg::MODE_PSM,
    deep_sleep_pkg::MODE_PSM_FALLBACK}), .support_i(support), .attached_o(attached),
    .detach_done_o(det_done), .attach_done_o(att_done), .granted_o(granted),
    .rejected_o(rejected), .tau_sent_o(tau_sent));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bounded wait on asleep (sel=1) or active (sel=0), then judge the level
  task automatic wait_st(input logic sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel ? asleep : active) !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    chk(sel ? asleep : active, lvl);
  endtask
  task automatic do_reset(input logic pon_n, input logic [31:0] tmr);
    @(posedge clock);
    arst_n <= 1'b0;
    pwr_n <= pon_n;
    wtimer <= tmr;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
  endtask
  task automatic pulse_req(input deep_sleep_pkg::sleep_mode_t m);
    @(posedge clock);
    mode <= m;
    req <= 1'b1;
    @(posedge clock);
    req <= 1'b0;
  endtask
  task automatic t_powerup();
    do_reset(1'b1, 32'h00000014);
    wait_st(1'b1, 1'b1, 4);
    wait_st(1'b1, 1'b0, 40);
    wait_st(1'b0, 1'b1, 40);
    do_reset(1'b0, 32'h0);
    wait_st(1'b0, 1'b1, 20);
  endtask
  task automatic t_standalone();
    @(posedge clock);
    wen <= 4'h5;
    wen_we <= 1'b1;
    @(posedge clock);
    wen_we <= 1'b0;
    pulse_req(deep_sleep_pkg::MODE_STANDALONE);
    wait_st(1'b1, 1'b1, 12);
    chk(ctl.app_cpu_on, 1'b0);
    chk(attached, 1'b0);
    @(posedge clock);
    wen <= 4'hA;
    wen_we <= 1'b1;
    evt <= 4'hA;
    @(posedge clock);
    wen_we <= 1'b0;
    evt <= 4'h0;
    tick(6);
    chk(asleep, 1'b1);
    chk(wen_o, 4'h5);
    @(posedge clock);
    evt <= 4'h4;
    @(posedge clock);
    evt <= 4'h0;
    wait_st(1'b1, 1'b0, 4);
    chk(cause, 4'h4);
    wait_st(1'b0, 1'b1, 30);
    tick(10);
    chk(active, 1'b1);
    chk(attached, 1'b1);
  endtask
  task automatic t_psm();
    pulse_req(deep_sleep_pkg::MODE_PSM);
    wait_st(1'b1, 1'b1, 12);
    chk(psm, 1'b1);
    chk(attached, 1'b1);
    tick(40);
    chk(asleep, 1'b1);
    wait_st(1'b1, 1'b0, 14);
    @(posedge clock);
    traffic <= 1'b1;
    tick(30);
    chk(asleep, 1'b0);
    @(posedge clock);
    traffic <= 1'b0;
    wait_st(1'b1, 1'b1, 24);
  endtask
  task automatic t_fallback();
    do_reset(1'b0, 32'h0);
    wait_st(1'b0, 1'b1, 20);
    @(posedge clock);
    support <= 1'b0;
    pulse_req(deep_sleep_pkg::MODE_PSM_FALLBACK);
    wait_st(1'b1, 1'b1, 16);
    chk(psm, 1'b0);
    do_reset(1'b0, 32'h0);
    wait_st(1'b0, 1'b1, 20);
    pulse_req(deep_sleep_pkg::MODE_PSM);
    tick(10);
    chk(active, 1'b1);
    pulse_req(deep_sleep_pkg::MODE_RSVD);
    tick(2);
    chk(merr, 1'b1);
    chk(asleep, 1'b0);
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    t_powerup();
    t_standalone();
    t_psm();
    t_fallback();
    print_verdict();
  end
endmodule
